// file: core/dcf_defines.svh
// constants for the flagged fifo block: register offsets, field positions, reset values
// assumes a 32-bit apb slave on a single 200 MHz clock
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

`define DCF_CLK_PERIOD_NS  5
`define DCF_DATA_W         9
`define DCF_OFS_W          16
`define DCF_OFS_DEFAULT    16'h0007

`define DCF_REG_EMPTY_OFS  12'h000
`define DCF_REG_FULL_OFS   12'h004
`define DCF_REG_STATUS     12'h008
`define DCF_REG_COUNT      12'h00C

`define DCF_ST_FULL_N      0
`define DCF_ST_AFULL_N     1
`define DCF_ST_AEMPTY_N    2
`define DCF_ST_EMPTY_N     3
`define DCF_ST_DUAL_WE     4
`define DCF_ST_LD_WSEL     8
`define DCF_ST_LD_RSEL     12

`endif

// file: core/dcf_fifo_flags.sv
// fifo with full, almost-full, almost-empty and empty flags, offset load and apb access
// assumes producer, consumer and apb master all run on CLOCK_I
//
// Register access over APB and the placing of the registers are this design's own decisions.
`include "dcf_defines.svh"

module dcf_fifo_flags #(
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [8:0]  DATA_I,
  input  wire logic        WRITE_ENABLE_PRIMARY_N_I,
  input  wire logic        WRITE_ENABLE_SECOND_OR_LOAD_I,
  input  wire logic        READ_ENABLE_PRIMARY_N_I,
  input  wire logic        READ_ENABLE_SECOND_N_I,
  input  wire logic        OUTPUT_ENABLE_N_I,
  output logic      [8:0]  DATA_O,
  output logic             DATA_OE_O,
  output logic             FULL_FLAG_N_O,
  output logic             ALMOST_FULL_FLAG_N_O,
  output logic             ALMOST_EMPTY_FLAG_N_O,
  output logic             EMPTY_FLAG_N_O,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O
);
  import dcf_pkg::*;

  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  typedef struct packed {
    logic                   strap_taken;
    logic                   dual_we;
    logic [PW-1:0]          wbin;
    logic [PW-1:0]          rbin;
    logic [PW-1:0]          wgray;
    logic [PW-1:0]          rgray;
    logic [PW-1:0]          wg_s1;
    logic [PW-1:0]          wg_s2;
    logic [PW-1:0]          rg_s1;
    logic [PW-1:0]          rg_s2;
    logic [`DCF_OFS_W-1:0]  empty_ofs;
    logic [`DCF_OFS_W-1:0]  full_ofs;
    dcf_ldsel_t             ld_wsel;
    dcf_ldsel_t             ld_rsel;
    logic                   q_sel_ofs;
    logic [7:0]             q_ofs;
    dcf_flags_t             flags;
    logic [31:0]            prdata;
    logic                   pslverr;
  } dcf_state_t;

  dcf_state_t    s;
  dcf_state_t    next_s;
  logic          wr_req;
  logic          wr_fire;
  logic          ofs_write;
  logic          rd_req;
  logic          rd_fire;
  logic          ofs_read;
  logic          apb_setup;
  logic          apb_write;
  logic [PW-1:0] wcount;
  logic [PW-1:0] rcount;
  logic [8:0]    ram_rdata;

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  always_comb begin
    next_s = s;
    // strap caught at first edge after reset release
    if (!s.strap_taken) begin
      next_s.strap_taken = 1'b1;
      next_s.dual_we     = WRITE_ENABLE_SECOND_OR_LOAD_I;
    end

    wr_req  = s.strap_taken & ~WRITE_ENABLE_PRIMARY_N_I & WRITE_ENABLE_SECOND_OR_LOAD_I;
    wr_fire = wr_req & s.flags.full_n;
    ofs_write = s.strap_taken & ~s.dual_we & ~WRITE_ENABLE_PRIMARY_N_I
                & ~WRITE_ENABLE_SECOND_OR_LOAD_I;
    rd_req  = s.strap_taken & ~READ_ENABLE_PRIMARY_N_I & ~READ_ENABLE_SECOND_N_I;
    ofs_read = rd_req & ~s.dual_we & ~WRITE_ENABLE_SECOND_OR_LOAD_I;
    rd_fire = rd_req & ~ofs_read & s.flags.empty_n;

    // apb offset writes, pin load below takes priority
    apb_setup = PSEL_I & ~PENABLE_I;
    apb_write = PSEL_I & PENABLE_I & PWRITE_I;
    // offsets frozen in dual enable mode
    if (apb_write && !s.dual_we && s.strap_taken) begin
      if (PADDR_I == `DCF_REG_EMPTY_OFS) begin
        next_s.empty_ofs = PWDATA_I[`DCF_OFS_W-1:0];
      end
      if (PADDR_I == `DCF_REG_FULL_OFS) begin
        next_s.full_ofs = PWDATA_I[`DCF_OFS_W-1:0];
      end
    end

    if (ofs_write) begin
      case (s.ld_wsel)
        DCF_LD_EMPTY_LO: next_s.empty_ofs[7:0]  = DATA_I[7:0];
        DCF_LD_EMPTY_HI: next_s.empty_ofs[15:8] = DATA_I[7:0];
        DCF_LD_FULL_LO:  next_s.full_ofs[7:0]   = DATA_I[7:0];
        DCF_LD_FULL_HI:  next_s.full_ofs[15:8]  = DATA_I[7:0];
        default:         next_s.empty_ofs[7:0]  = DATA_I[7:0];
      endcase
      next_s.ld_wsel = dcf_ld_next(s.ld_wsel);
    end

    // offset readback uses the same order
    if (ofs_read) begin
      case (s.ld_rsel)
        DCF_LD_EMPTY_LO: next_s.q_ofs = s.empty_ofs[7:0];
        DCF_LD_EMPTY_HI: next_s.q_ofs = s.empty_ofs[15:8];
        DCF_LD_FULL_LO:  next_s.q_ofs = s.full_ofs[7:0];
        DCF_LD_FULL_HI:  next_s.q_ofs = s.full_ofs[15:8];
        default:         next_s.q_ofs = s.empty_ofs[7:0];
      endcase
      next_s.ld_rsel   = dcf_ld_next(s.ld_rsel);
      next_s.q_sel_ofs = 1'b1;
    end else if (rd_fire) begin
      next_s.q_sel_ofs = 1'b0;
    end

    // pointer advance
    if (wr_fire) begin
      next_s.wbin = s.wbin + PW'(1);
    end
    if (rd_fire) begin
      next_s.rbin = s.rbin + PW'(1);
    end
    next_s.wgray = bin2gray(next_s.wbin);
    next_s.rgray = bin2gray(next_s.rbin);

    next_s.wg_s1 = s.wgray;
    next_s.wg_s2 = s.wg_s1;
    next_s.rg_s1 = s.rgray;
    next_s.rg_s2 = s.rg_s1;

    // write side sees reads after sync delay
    wcount = next_s.wbin - gray2bin(s.rg_s2);
    // read side sees writes after sync delay
    rcount = gray2bin(s.wg_s2) - next_s.rbin;

    next_s.flags.empty_n  = (rcount != '0);
    next_s.flags.full_n   = (wcount != DEPTH_P);
    next_s.flags.aempty_n = (32'(rcount) > 32'(s.empty_ofs));
    // almost-full at depth minus m or more
    next_s.flags.afull_n  = ((32'(wcount) + 32'(s.full_ofs)) < 32'(DEPTH));

    // apb read data and error captured in the setup cycle
    if (apb_setup) begin
      next_s.pslverr = 1'b0;
      next_s.prdata  = '0;
      case (PADDR_I)
        `DCF_REG_EMPTY_OFS: next_s.prdata[`DCF_OFS_W-1:0] = s.empty_ofs;
        `DCF_REG_FULL_OFS:  next_s.prdata[`DCF_OFS_W-1:0] = s.full_ofs;
        `DCF_REG_STATUS: begin
          next_s.prdata[`DCF_ST_FULL_N]   = s.flags.full_n;
          next_s.prdata[`DCF_ST_AFULL_N]  = s.flags.afull_n;
          next_s.prdata[`DCF_ST_AEMPTY_N] = s.flags.aempty_n;
          next_s.prdata[`DCF_ST_EMPTY_N]  = s.flags.empty_n;
          next_s.prdata[`DCF_ST_DUAL_WE]  = s.dual_we;
          next_s.prdata[`DCF_ST_LD_WSEL +: 2] = s.ld_wsel;
          next_s.prdata[`DCF_ST_LD_RSEL +: 2] = s.ld_rsel;
        end
        `DCF_REG_COUNT: begin
          next_s.prdata[15:0]  = 16'(wcount);
          next_s.prdata[31:16] = 16'(rcount);
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end
  end

  // plain async reset, clock may keep running
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s.strap_taken <= 1'b0;
      s.dual_we     <= 1'b0;
      s.wbin        <= '0;
      s.rbin        <= '0;
      s.wgray       <= '0;
      s.rgray       <= '0;
      s.wg_s1       <= '0;
      s.wg_s2       <= '0;
      s.rg_s1       <= '0;
      s.rg_s2       <= '0;
      s.empty_ofs   <= `DCF_OFS_DEFAULT;
      s.full_ofs    <= `DCF_OFS_DEFAULT;
      s.ld_wsel     <= DCF_LD_EMPTY_LO;
      s.ld_rsel     <= DCF_LD_EMPTY_LO;
      s.q_sel_ofs   <= 1'b0;
      s.q_ofs       <= 8'h00;
      s.flags       <= '{full_n: 1'b1, afull_n: 1'b1, aempty_n: 1'b0, empty_n: 1'b0};
      s.prdata      <= 32'h0000_0000;
      s.pslverr     <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // first word lands in output register on the first accepted read
  dcf_ram #(
    .WIDTH (`DCF_DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_ram (
    .clk_i     (CLOCK_I),
    .rst_n_i   (RESET_N_I),
    .wr_en_i   (wr_fire),
    .wr_addr_i (s.wbin[AW-1:0]),
    .wr_data_i (DATA_I),
    .rd_en_i   (rd_fire),
    .rd_addr_i (s.rbin[AW-1:0]),
    .rd_data_o (ram_rdata)
  );

  // output enable drives the data pins, follows OUTPUT_ENABLE_N_I directly with no reset
  assign DATA_OE_O = ~OUTPUT_ENABLE_N_I;
  assign DATA_O    = s.q_sel_ofs ? {1'b0, s.q_ofs} : ram_rdata;

  assign FULL_FLAG_N_O         = s.flags.full_n;
  assign ALMOST_FULL_FLAG_N_O  = s.flags.afull_n;
  assign ALMOST_EMPTY_FLAG_N_O = s.flags.aempty_n;
  assign EMPTY_FLAG_N_O        = s.flags.empty_n;

  assign PRDATA_O  = s.prdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = s.pslverr & PSEL_I & PENABLE_I;

endmodule

// file: core/dcf_pkg.sv
// types shared by the flagged fifo block
// assumes dcf_defines.svh supplies the numeric constants
package dcf_pkg;

  typedef enum logic [1:0] {
    DCF_LD_EMPTY_LO,
    DCF_LD_EMPTY_HI,
    DCF_LD_FULL_LO,
    DCF_LD_FULL_HI
  } dcf_ldsel_t;

  typedef struct packed {
    logic full_n;
    logic afull_n;
    logic aempty_n;
    logic empty_n;
  } dcf_flags_t;

  function automatic dcf_ldsel_t dcf_ld_next(input dcf_ldsel_t sel);
    dcf_ldsel_t r;
    r = DCF_LD_EMPTY_LO;
    case (sel)
      DCF_LD_EMPTY_LO: r = DCF_LD_EMPTY_HI;
      DCF_LD_EMPTY_HI: r = DCF_LD_FULL_LO;
      DCF_LD_FULL_LO:  r = DCF_LD_FULL_HI;
      DCF_LD_FULL_HI:  r = DCF_LD_EMPTY_LO;
      default:         r = DCF_LD_EMPTY_LO;
    endcase
    return r;
  endfunction

endpackage

// file: core/dcf_ram.sv
// storage array of the fifo with a registered read port
// assumes write and read addresses come from the fifo pointers on the same clock
module dcf_ram #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_en_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // array write, no reset on storage
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // output register holds its word until the next read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// file: tb/dcf_fifo_flags_sva.sv
// checker on the flag, data and enable pins of the flagged fifo
// assumes binding to the ports of dcf_fifo_flags
module dcf_fifo_flags_sva (
  input wire logic       CLOCK_I,
  input wire logic       RESET_N_I,
  input wire logic       WRITE_ENABLE_PRIMARY_N_I,
  input wire logic       WRITE_ENABLE_SECOND_OR_LOAD_I,
  input wire logic       READ_ENABLE_PRIMARY_N_I,
  input wire logic       READ_ENABLE_SECOND_N_I,
  input wire logic       OUTPUT_ENABLE_N_I,
  input wire logic [8:0] DATA_O,
  input wire logic       DATA_OE_O,
  input wire logic       FULL_FLAG_N_O,
  input wire logic       ALMOST_FULL_FLAG_N_O,
  input wire logic       ALMOST_EMPTY_FLAG_N_O,
  input wire logic       EMPTY_FLAG_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  logic rd_off;
  logic wr_on;
  assign rd_off = READ_ENABLE_PRIMARY_N_I | READ_ENABLE_SECOND_N_I;
  assign wr_on  = !WRITE_ENABLE_PRIMARY_N_I & WRITE_ENABLE_SECOND_OR_LOAD_I & FULL_FLAG_N_O;
  a_oe_drive: assert property (DATA_OE_O == !OUTPUT_ENABLE_N_I)
    else $error("data enable wrong");
  a_rst_flags: assert property ($rose(RESET_N_I) |->
    {FULL_FLAG_N_O, ALMOST_FULL_FLAG_N_O, ALMOST_EMPTY_FLAG_N_O, EMPTY_FLAG_N_O} == 4'hC)
    else $error("flags wrong after reset");
  a_empty_ae: assert property (!EMPTY_FLAG_N_O |-> !ALMOST_EMPTY_FLAG_N_O)
    else $error("empty without almost empty");
  a_full_af: assert property (!FULL_FLAG_N_O |-> !ALMOST_FULL_FLAG_N_O)
    else $error("full without almost full");
  a_full_not_empty: assert property (!FULL_FLAG_N_O |-> EMPTY_FLAG_N_O && ALMOST_EMPTY_FLAG_N_O)
    else $error("full with empty flags low");
  a_rd_hold: assert property (rd_off |=> $stable(DATA_O))
    else $error("data moved without read");
  a_empty_hold: assert property (!EMPTY_FLAG_N_O && !rd_off && WRITE_ENABLE_SECOND_OR_LOAD_I
    |=> $stable(DATA_O))
    else $error("read taken while empty");
  a_empty_rise: assert property (!EMPTY_FLAG_N_O && wr_on |-> ##[2:4] EMPTY_FLAG_N_O)
    else $error("empty flag late");
  a_full_stay: assert property ((!FULL_FLAG_N_O && rd_off) [*5] |=> !FULL_FLAG_N_O)
    else $error("full left without read");
  a_af_before_full: assert property ($fell(FULL_FLAG_N_O) |-> !$past(ALMOST_FULL_FLAG_N_O))
    else $error("almost full skipped");
endmodule

bind dcf_fifo_flags dcf_fifo_flags_sva u_dcf_fifo_flags_sva (
  .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .OUTPUT_ENABLE_N_I(OUTPUT_ENABLE_N_I),
  .WRITE_ENABLE_PRIMARY_N_I(WRITE_ENABLE_PRIMARY_N_I),
  .WRITE_ENABLE_SECOND_OR_LOAD_I(WRITE_ENABLE_SECOND_OR_LOAD_I),
  .READ_ENABLE_PRIMARY_N_I(READ_ENABLE_PRIMARY_N_I),
  .READ_ENABLE_SECOND_N_I(READ_ENABLE_SECOND_N_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
  .FULL_FLAG_N_O(FULL_FLAG_N_O), .ALMOST_FULL_FLAG_N_O(ALMOST_FULL_FLAG_N_O),
  .ALMOST_EMPTY_FLAG_N_O(ALMOST_EMPTY_FLAG_N_O), .EMPTY_FLAG_N_O(EMPTY_FLAG_N_O));

// file: tb/dcf_fifo_flags_test.sv
// self-checking bench for the flagged fifo
// assumes one 200 MHz clock for pins and apb
module dcf_fifo_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 64;
  logic        clk = 0, rst_n = 0, strap = 1, oe_n = 1, wr_go = 0, rd_go = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [8:0]  wdat = 0, din, dout;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        wen_n, ren_n, read_enable_second_n_n, oe, ff, af, ae, ef, pready, pslverr, e;
  logic        sff, saf, sae, sef;
  int          failures = 0, n_checks = 0, wn, rn;
  initial forever #2.5 clk = ~clk;
  dcf_pc_model u_dcf_pc_model (.wr_go_i(wr_go), .rd_go_i(rd_go), .wdat_i(wdat),
    .full_n_i(ff), .empty_n_i(ef), .afull_n_i(af), .aempty_n_i(ae), .wen_n_o(wen_n),
    .ren_n_o(ren_n), .read_enable_second_n_n_o(read_enable_second_n_n), .data_o(din), .sys_full_n_o(sff),
    .sys_empty_n_o(sef), .sys_afull_n_o(saf), .sys_aempty_n_o(sae));
  dcf_fifo_flags #(.DEPTH(D)) u_dcf_fifo_flags (.CLOCK_I(clk), .RESET_N_I(rst_n),
    .DATA_I(din), .WRITE_ENABLE_PRIMARY_N_I(wen_n), .WRITE_ENABLE_SECOND_OR_LOAD_I(strap),
    .READ_ENABLE_PRIMARY_N_I(ren_n), .READ_ENABLE_SECOND_N_I(read_enable_second_n_n),
    .OUTPUT_ENABLE_N_I(oe_n), .DATA_O(dout), .DATA_OE_O(oe), .FULL_FLAG_N_O(ff),
    .ALMOST_FULL_FLAG_N_O(af), .ALMOST_EMPTY_FLAG_N_O(ae), .EMPTY_FLAG_N_O(ef),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic do_reset(input logic mode);
    rst_n <= 0;
    strap <= mode;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    wn = 0;
    rn = 0;
  endtask
  task automatic wr(input int k);
    repeat (k) begin
      wr_go <= 1;
      wdat <= 9'(wn);
      wn++;
      @(posedge clk);
    end
    wr_go <= 0;
  endtask
  task automatic rd(input int k);
    rd_go <= 1;
    for (int i = 0; i <= k; i++) begin
      @(posedge clk);
      if (i == k - 1) rd_go <= 0;
      if (i > 0) chk(dout, 9'(rn + i - 1));
    end
    rn += k;
  endtask
  task automatic flags(input int c, input int n, input int m);
    repeat (5) @(posedge clk);
    chk({ff, af, ae, ef}, {c != D, c < D - m, c > n, c != 0});
    chk({sff, saf, sae, sef}, {c != D, c < D - m, c > n, c != 0});
  endtask
  task automatic t_fill(input int n, input int m);
    int lv[7];
    int cur;
    lv = '{1, n, n + 1, D - m - 1, D - m, D - 1, D};
    cur = 0;
    foreach (lv[i]) begin
      wr(lv[i] - cur);
      cur = lv[i];
      flags(cur, n, m);
    end
    wr(1);
    wn--;
    flags(D, n, m);
    for (int i = 5; i >= 0; i--) begin
      rd(cur - lv[i]);
      cur = lv[i];
      flags(cur, n, m);
    end
    rd(1);
    flags(0, n, m);
    rd_go <= 1;
    repeat (3) @(posedge clk);
    rd_go <= 0;
    chk(dout, 9'(rn - 1));
    $display("fill test done n %0d m %0d", n, m);
  endtask
  task automatic t_dual();
    do_reset(1);
    chk(oe, 0);
    oe_n <= 0;
    strap <= 0;
    wr(3);
    strap <= 1;
    rn = wn;
    chk({oe, dout}, 10'h200);
    flags(0, 7, 7);
    apb(1, 12'h000, 32'h0000_0003, r);
    apb(0, 12'h000, 32'h0000_0000, r);
    chk(r, 7);
    apb(0, 12'h008, 32'h0000_0000, r);
    chk(r[4], 1);
    t_fill(7, 7);
    $display("dual test done");
  endtask
  task automatic t_load();
    logic [8:0] b[5];
    b = '{9'h009, 9'h000, 9'h005, 9'h000, 9'h003};
    do_reset(0);
    foreach (b[i]) begin
      wr_go <= 1;
      wdat <= b[i];
      @(posedge clk);
    end
    wr_go <= 0;
    rd_go <= 1;
    @(posedge clk);
    rd_go <= 0;
    @(posedge clk);
    chk(dout, 9'h003);
    apb(0, 12'h000, 32'h0000_0000, r);
    chk(r, 3);
    apb(0, 12'h004, 32'h0000_0000, r);
    chk(r, 5);
    apb(0, 12'h008, 32'h0000_0000, r);
    chk(r[4], 0);
    apb(0, 12'h010, 32'h0000_0000, r);
    chk({e, r}, 33'h100000000);
    apb(1, 12'h004, 32'h0000_0006, r);
    apb(0, 12'h004, 32'h0000_0000, r);
    chk(r, 6);
    strap <= 1;
    t_fill(3, 6);
    $display("load test done");
  endtask
  initial begin
    t_dual();
    t_load();
    print_verdict();
  end
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
endmodule

// file: tb/dcf_pc_model.sv
// producer and consumer logic on the fifo pins, with the flag merge of a wide arrangement
// assumes the bench steps it just after rising clock edges
module dcf_pc_model #(
  parameter int LANES = 1
) (
  input  wire logic             wr_go_i,
  input  wire logic             rd_go_i,
  input  wire logic [8:0]       wdat_i,
  input  wire logic [LANES-1:0] full_n_i,
  input  wire logic [LANES-1:0] empty_n_i,
  input  wire logic [LANES-1:0] afull_n_i,
  input  wire logic [LANES-1:0] aempty_n_i,
  output logic                  wen_n_o,
  output logic                  ren_n_o,
  output logic                  read_enable_second_n_n_o,
  output logic      [8:0]       data_o,
  output logic                  sys_full_n_o,
  output logic                  sys_empty_n_o,
  output logic                  sys_afull_n_o,
  output logic                  sys_aempty_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign wen_n_o = !wr_go_i;
  assign ren_n_o = !rd_go_i;
  assign read_enable_second_n_n_o = 1'b0;
  // idle data shows the inverse
  assign data_o = wr_go_i ? wdat_i : ~wdat_i;
  assign sys_full_n_o  = &full_n_i;
  assign sys_empty_n_o = &empty_n_i;
  assign sys_afull_n_o  = afull_n_i[0];
  assign sys_aempty_n_o = aempty_n_i[0];
endmodule
